// ===== hw/channel_sequencing_timers.v
/*
  Four-channel power-up / power-down sequencing timers with a
  control-pin restart hold-off and a paged command register port.
  Assumes all inputs are synchronous to i_clock and that the serial
  bus front end presents one decoded command per i_cmd_valid pulse.
*/
// Notes on behaviour
// - Enable output rises after on-delay, counted on shared timebase only.
// - After rise time on shared timebase, soft-connect DAC when mode is 00.
// - Output not at UV limit within timeout after enable raises fault.
// - UV comparison masked in power-up, unmasked once output reaches limit.
// - A zero timeout setting disables the power-up timeout entirely.
// - Off request waits off-delay then soft-off; shared or internal timebase.
// - Sequencing delays clamp at 655 ms, rounded to nearest 10 us step.
// - Reads return the word last written, never the clamped value.
// - Control off 10 us then on: dependents held off restart time.
// - Off periods longer than hold time pass unchanged.
// - A restart hold setting of zero disables the hold-off.
// - Restart hold clamps at 13.1 s, rounded to nearest 200 us.
// - Timer words are 16-bit ms values; on/off delays paged, hold not.
// - Rise time and timeout reset to 10 ms and 15 ms words.
`default_nettype none
`include "channel_seq_defs.vh"

module channel_sequencing_timers (
  // Clock and reset
  input  wire        i_clock,
  input  wire        i_rst,
  // Command port
  input  wire        i_cmd_valid,
  input  wire        i_cmd_write,
  input  wire [7:0]  i_cmd_code,
  input  wire [1:0]  i_cmd_page,
  input  wire [15:0] i_cmd_wdata,
  output wire [15:0] o_cmd_rdata,
  output wire        o_cmd_rvalid,
  output wire        o_cmd_nack,
  // Timebase
  input  wire        i_share_clk,
  input  wire        i_share_clk_ok,
  // Channel control
  input  wire        i_control_pin,
  input  wire [3:0]  i_op_on,
  input  wire [3:0]  i_dependent,
  input  wire [3:0]  i_uv_reached,
  input  wire [7:0]  i_dac_mode,
  // Channel outputs
  output wire [3:0]  o_converter_enable_out,
  output wire [3:0]  o_dac_soft_connect,
  output wire [3:0]  o_uv_unmask,
  output wire [3:0]  o_power_up_timeout_fault
);

  localparam [2:0] ST_OFF      = 3'd0;
  localparam [2:0] ST_WAIT_ON  = 3'd1;
  localparam [2:0] ST_RISE     = 3'd2;
  localparam [2:0] ST_ON       = 3'd3;
  localparam [2:0] ST_WAIT_OFF = 3'd4;

  // ==========================================================
  // Linear word to timer steps
  // ==========================================================
  // linear word decode
  function [15:0] l11_steps;
    input [15:0] w;
    input [7:0]  per_ms;
    reg   [4:0]  e;
    reg   [47:0] p;
    reg   [5:0]  sh;
    begin
      e = w[`L11_EXP_MSB:`L11_EXP_LSB];
      p = {38'h0, w[`L11_MAN_MSB-1:`L11_MAN_LSB]} * {40'h0, per_ms};
      sh = {1'b0, 5'h0 - e};
      if (w[`L11_MAN_MSB]) begin
        p = 48'h0;
      end else if (e[4]) begin
        p = (p + (48'h1 << (sh - 6'h1))) >> sh;
      end else begin
        p = p << e[3:0];
      end
      l11_steps = (|p[47:16]) ? `SEQ_TICK_MAX : p[15:0];
    end
  endfunction

  // ==========================================================
  // Setting registers
  // ==========================================================
  reg [15:0] on_delay_q   [0:3];
  reg [15:0] rise_time_q  [0:3];
  reg [15:0] pu_timeout_q [0:3];
  reg [15:0] off_delay_q  [0:3];
  reg [15:0] restart_hold_q;
  reg [15:0] rdata_q;
  reg        rvalid_q;
  reg        nack_q;
  reg [15:0] rdata_d;
  reg        hit_d;
  integer    k;

  always @* begin
    rdata_d = 16'h0000;
    hit_d = 1'b1;
    case (i_cmd_code)
      `CMD_ON_DELAY:     rdata_d = on_delay_q[i_cmd_page];
      `CMD_RISE_TIME:    rdata_d = rise_time_q[i_cmd_page];
      `CMD_PU_TIMEOUT:   rdata_d = pu_timeout_q[i_cmd_page];
      `CMD_OFF_DELAY:    rdata_d = off_delay_q[i_cmd_page];
      `CMD_RESTART_HOLD: rdata_d = restart_hold_q;
      default:           hit_d = 1'b0;
    endcase
  end

  always @(posedge i_clock) begin
    if (i_rst) begin
      for (k = 0; k < 4; k = k + 1) begin
        on_delay_q[k]   <= `RST_ON_DELAY;
        rise_time_q[k]  <= `RST_RISE_TIME;
        pu_timeout_q[k] <= `RST_PU_TIMEOUT;
        off_delay_q[k]  <= `RST_OFF_DELAY;
      end
      restart_hold_q <= `RST_RESTART_HOLD;
      rdata_q <= 16'h0000;
      rvalid_q <= 1'b0;
      nack_q <= 1'b0;
    end else begin
      rvalid_q <= i_cmd_valid & ~i_cmd_write & hit_d;
      nack_q <= i_cmd_valid & ~hit_d;
      if (i_cmd_valid & ~i_cmd_write & hit_d) begin
        rdata_q <= rdata_d;
      end
      if (i_cmd_valid & i_cmd_write) begin
        case (i_cmd_code)
          `CMD_ON_DELAY:     on_delay_q[i_cmd_page] <= i_cmd_wdata;
          `CMD_RISE_TIME:    rise_time_q[i_cmd_page] <= i_cmd_wdata;
          `CMD_PU_TIMEOUT:   pu_timeout_q[i_cmd_page] <= i_cmd_wdata;
          `CMD_OFF_DELAY:    off_delay_q[i_cmd_page] <= i_cmd_wdata;
          `CMD_RESTART_HOLD: restart_hold_q <= i_cmd_wdata;
          default: ;
        endcase
      end
    end
  end

  // ==========================================================
  // Timebase
  // ==========================================================
  // The shared clock is open-drain and the fastest part owns it, so
  // the falling edge is the common reference for every device.
  reg        share_prev_q;
  reg [9:0]  int_div_q;
  reg [4:0]  hold_div_q;
  reg        int_tick_q;
  wire       share_tick = share_prev_q & ~i_share_clk & i_share_clk_ok;
  wire       hold_tick = share_tick & ({27'h0, hold_div_q} == `SEQ_HOLD_DIV - 1);
  wire       off_tick = i_share_clk_ok ? share_tick : int_tick_q;
  wire       int_wrap = ({22'h0, int_div_q} == `SEQ_STEP_CYC - 1);

  always @(posedge i_clock) begin
    if (i_rst) begin
      share_prev_q <= 1'b1;
      int_div_q <= 10'h000;
      hold_div_q <= 5'h00;
      int_tick_q <= 1'b0;
    end else begin
      share_prev_q <= i_share_clk;
      int_tick_q <= int_wrap;
      int_div_q <= int_wrap ? 10'h000 : int_div_q + 10'h001;
      hold_div_q <= hold_tick ? 5'h00 : hold_div_q + {4'h0, share_tick};
    end
  end

  // ==========================================================
  // Control pin restart hold-off
  // ==========================================================
  reg        ctrl_virt_q;
  reg [9:0]  glitch_cnt_q;
  reg [15:0] hold_cnt_q;
  wire [15:0] hold_steps = l11_steps(restart_hold_q, `HOLD_STEPS_PER_MS);
  wire        hold_off_en = |restart_hold_q;

  always @(posedge i_clock) begin
    if (i_rst) begin
      ctrl_virt_q <= 1'b0;
      glitch_cnt_q <= 10'h000;
      hold_cnt_q <= `SEQ_TICK_MAX;
    end else if (!hold_off_en) begin
      ctrl_virt_q <= i_control_pin;
      glitch_cnt_q <= 10'h000;
      hold_cnt_q <= `SEQ_TICK_MAX;
    end else begin
      if (i_control_pin) begin
        glitch_cnt_q <= 10'h000;
      end else if ({22'h0, glitch_cnt_q} != `SEQ_DEGLITCH_CYC - 1) begin
        glitch_cnt_q <= glitch_cnt_q + 10'h001;
      end
      if (ctrl_virt_q) begin
        if (!i_control_pin && ({22'h0, glitch_cnt_q} == `SEQ_DEGLITCH_CYC - 1)) begin
          ctrl_virt_q <= 1'b0;
          hold_cnt_q <= 16'h0000;
        end
      end else begin
        if (i_control_pin && hold_cnt_q >= hold_steps) begin
          ctrl_virt_q <= 1'b1;
        end else if (hold_tick && hold_cnt_q != `SEQ_TICK_MAX) begin
          hold_cnt_q <= hold_cnt_q + 16'h0001;
        end
      end
    end
  end

  // ==========================================================
  // Channel sequencers
  // ==========================================================
  reg [2:0]  st_q      [0:3];
  reg [15:0] seq_cnt_q [0:3];
  reg [15:0] tmo_cnt_q [0:3];
  reg [3:0]  en_q;
  reg [3:0]  dac_q;
  reg [3:0]  unmask_q;
  reg [3:0]  fault_q;
  wire [3:0] chan_req = i_op_on & (~i_dependent | {4{ctrl_virt_q}});
  integer    i;

  always @(posedge i_clock) begin
    if (i_rst) begin
      for (i = 0; i < 4; i = i + 1) begin
        st_q[i] <= ST_OFF;
        seq_cnt_q[i] <= 16'h0000;
        tmo_cnt_q[i] <= 16'h0000;
      end
      en_q <= 4'h0;
      dac_q <= 4'h0;
      unmask_q <= 4'h0;
      fault_q <= 4'h0;
    end else begin
      for (i = 0; i < 4; i = i + 1) begin
        if (en_q[i] && !unmask_q[i] && !fault_q[i]) begin
          if (i_uv_reached[i]) begin
            unmask_q[i] <= 1'b1;
          end else if (|pu_timeout_q[i][`L11_MAN_MSB:`L11_MAN_LSB] &&
                       tmo_cnt_q[i] >= l11_steps(pu_timeout_q[i], `SEQ_STEPS_PER_MS)) begin
            fault_q[i] <= 1'b1;
          end else if (share_tick && tmo_cnt_q[i] != `SEQ_TICK_MAX) begin
            tmo_cnt_q[i] <= tmo_cnt_q[i] + 16'h0001;
          end
        end
        case (st_q[i])
          ST_OFF: begin
            if (chan_req[i]) begin
              st_q[i] <= ST_WAIT_ON;
              seq_cnt_q[i] <= 16'h0000;
            end
          end
          ST_WAIT_ON: begin
            if (!chan_req[i]) begin
              st_q[i] <= ST_OFF;
            end else if (seq_cnt_q[i] >= l11_steps(on_delay_q[i], `SEQ_STEPS_PER_MS)) begin
              st_q[i] <= ST_RISE;
              en_q[i] <= 1'b1;
              fault_q[i] <= 1'b0;
              seq_cnt_q[i] <= 16'h0000;
              tmo_cnt_q[i] <= 16'h0000;
            end else if (share_tick) begin
              seq_cnt_q[i] <= seq_cnt_q[i] + 16'h0001;
            end
          end
          ST_RISE: begin
            if (!chan_req[i]) begin
              st_q[i] <= ST_WAIT_OFF;
              seq_cnt_q[i] <= 16'h0000;
            end else if (seq_cnt_q[i] >= l11_steps(rise_time_q[i], `SEQ_STEPS_PER_MS)) begin
              st_q[i] <= ST_ON;
              dac_q[i] <= (i_dac_mode[2*i+1] == 1'b0) && (i_dac_mode[2*i] == 1'b0);
            end else if (share_tick) begin
              seq_cnt_q[i] <= seq_cnt_q[i] + 16'h0001;
            end
          end
          ST_ON: begin
            if (!chan_req[i]) begin
              st_q[i] <= ST_WAIT_OFF;
              seq_cnt_q[i] <= 16'h0000;
            end
          end
          ST_WAIT_OFF: begin
            // A new on request here is held until the channel is fully off,
            // so the on-delay always starts from a discharged output.
            if (seq_cnt_q[i] >= l11_steps(off_delay_q[i], `SEQ_STEPS_PER_MS)) begin
              st_q[i] <= ST_OFF;
              en_q[i] <= 1'b0;
              dac_q[i] <= 1'b0;
              unmask_q[i] <= 1'b0;
            end else if (off_tick) begin
              seq_cnt_q[i] <= seq_cnt_q[i] + 16'h0001;
            end
          end
          default: begin
            st_q[i] <= ST_OFF;
            en_q[i] <= 1'b0;
            dac_q[i] <= 1'b0;
            unmask_q[i] <= 1'b0;
          end
        endcase
      end
    end
  end

  // ==========================================================
  // Outputs
  // ==========================================================
  assign o_cmd_rdata = rdata_q;
  assign o_cmd_rvalid = rvalid_q;
  assign o_cmd_nack = nack_q;
  assign o_converter_enable_out = en_q;
  assign o_dac_soft_connect = dac_q;
  assign o_uv_unmask = unmask_q;
  assign o_power_up_timeout_fault = fault_q;

endmodule
`default_nettype wire

// ===== shared/channel_seq_defs.vh
/*
  Constants for the channel sequencing timers: command codes, reset
  words, linear-format field positions and timebase figures.
  Assumes a 100 MHz system clock and a shared timebase whose
  falling edges arrive one per 10 us step.
*/
`ifndef CHANNEL_SEQ_DEFS_VH
`define CHANNEL_SEQ_DEFS_VH

// ==========================================================
// Command codes
// ==========================================================
`define CMD_ON_DELAY      8'h60
`define CMD_RISE_TIME     8'h61
`define CMD_PU_TIMEOUT    8'h62
`define CMD_OFF_DELAY     8'h64
`define CMD_RESTART_HOLD  8'hDC

// ==========================================================
// Reset words
// ==========================================================
`define RST_ON_DELAY      16'hBA00
`define RST_RISE_TIME     16'hD280
`define RST_PU_TIMEOUT    16'hD3C0
`define RST_OFF_DELAY     16'hBA00
`define RST_RESTART_HOLD  16'hFB20

// ==========================================================
// Linear word fields
// ==========================================================
`define L11_EXP_MSB       15
`define L11_EXP_LSB       11
`define L11_MAN_MSB       10
`define L11_MAN_LSB       0

// ==========================================================
// Timebase
// ==========================================================
`define SEQ_CLK_MHZ       100
`define SEQ_STEP_US       10
`define SEQ_HOLD_STEP_US  200
`define SEQ_DEGLITCH_US   10
`define SEQ_STEP_CYC      (`SEQ_CLK_MHZ * `SEQ_STEP_US)
`define SEQ_DEGLITCH_CYC  (`SEQ_CLK_MHZ * `SEQ_DEGLITCH_US)
`define SEQ_HOLD_DIV      (`SEQ_HOLD_STEP_US / `SEQ_STEP_US)
`define SEQ_STEPS_PER_MS  8'd100
`define HOLD_STEPS_PER_MS 8'd5
`define SEQ_TICK_MAX      16'hFFFF

`endif

// ===== verif/channel_sequencing_timers_monitor.sv
/* Checker for the sequencing timers, watching the top module's ports.
   Assumes one clock domain and a synchronous active-high reset. */
`default_nettype none
`include "channel_seq_defs.vh"
module channel_sequencing_timers_monitor (
  // Clock and reset
  input wire logic        i_clock,
  input wire logic        i_rst,
  // Command port
  input wire logic        i_cmd_valid,
  input wire logic        i_cmd_write,
  input wire logic [7:0]  i_cmd_code,
  input wire logic [1:0]  i_cmd_page,
  input wire logic [15:0] i_cmd_wdata,
  input wire logic [15:0] o_cmd_rdata,
  input wire logic        o_cmd_rvalid,
  input wire logic        o_cmd_nack,
  // Timebase and control
  input wire logic        i_share_clk,
  input wire logic        i_share_clk_ok,
  input wire logic        i_control_pin,
  input wire logic [3:0]  i_op_on,
  input wire logic [3:0]  i_dependent,
  input wire logic [3:0]  i_uv_reached,
  input wire logic [7:0]  i_dac_mode,
  // Channel outputs
  input wire logic [3:0]  o_converter_enable_out,
  input wire logic [3:0]  o_dac_soft_connect,
  input wire logic [3:0]  o_uv_unmask,
  input wire logic [3:0]  o_power_up_timeout_fault
);
  timeunit 1ns;
  timeprecision 1ps;
  wire logic mapped = i_cmd_code inside {`CMD_ON_DELAY, `CMD_RISE_TIME, `CMD_PU_TIMEOUT,
                                         `CMD_OFF_DELAY, `CMD_RESTART_HOLD};
  wire logic rd_req = i_cmd_valid & ~i_cmd_write & mapped;
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);
  // ===
  // Command port
  sequence s_read; rd_req; endsequence
  sequence s_write; i_cmd_valid && i_cmd_write && mapped; endsequence
  sequence s_bad; i_cmd_valid && !mapped; endsequence
  AST_READ_ANSWER: assert property (s_read |=> o_cmd_rvalid && !o_cmd_nack)
    else $error("read not answered");
  AST_WRITE_SILENT: assert property (s_write |=> !o_cmd_rvalid && !o_cmd_nack)
    else $error("write answered");
  AST_BAD_NACK: assert property (s_bad |=> o_cmd_nack && !o_cmd_rvalid)
    else $error("unmapped code not refused");
  AST_RVALID_CAUSE: assert property (o_cmd_rvalid |-> $past(rd_req))
    else $error("read answer without read");
  AST_RDATA_HOLD: assert property (!o_cmd_rvalid |-> $stable(o_cmd_rdata))
    else $error("read word moved without read");
  // ===
  // Channel sequencing
  for (genvar n = 0; n < 4; n++) begin : g_ch
    AST_EN_CAUSE: assert property ($rose(o_converter_enable_out[n]) |-> $past(i_op_on[n]))
      else $error("enable rose without request");
    AST_DAC_CAUSE: assert property ($rose(o_dac_soft_connect[n]) |->
      o_converter_enable_out[n] && $past(i_dac_mode[2*n +: 2]) == 2'h0)
      else $error("soft-connect without enable or mode 00");
    AST_UNMASK_CAUSE: assert property ($rose(o_uv_unmask[n]) |->
      o_converter_enable_out[n] && $past(i_uv_reached[n]))
      else $error("unmask without output at limit");
    AST_FAULT_CAUSE: assert property ($rose(o_power_up_timeout_fault[n]) |->
      o_converter_enable_out[n] && !o_uv_unmask[n] && !$past(i_uv_reached[n]))
      else $error("timeout fault after output reached limit");
  end
endmodule
`default_nettype wire

// ===== verif/channel_sequencing_timers_test.sv
/* Top bench for the sequencing timers: commands, shared timebase, controls.
   Assumes the converter model on the far side and the bound checker. */
`default_nettype none
`include "channel_seq_defs.vh"
module channel_sequencing_timers_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        i_clock = 1'h0, i_rst = 1'h1, i_cmd_valid = 1'h0, i_cmd_write = 1'h0;
  logic [7:0]  i_cmd_code = 8'h00, i_dac_mode = 8'h04;
  logic [1:0]  i_cmd_page = 2'h0;
  logic [15:0] i_cmd_wdata = 16'h0000, o_cmd_rdata;
  logic        i_share_clk = 1'h1, i_share_clk_ok = 1'h1, i_control_pin = 1'h1;
  logic        share_run = 1'h1, o_cmd_rvalid, o_cmd_nack;
  logic [3:0]  i_op_on = 4'h0, i_dependent = 4'h8, stuck = 4'h0, i_uv_reached;
  logic [3:0]  o_converter_enable_out, o_dac_soft_connect, o_uv_unmask, o_power_up_timeout_fault;
  int          failures = 0, samples_checked = 0, cycles = 0;
  channel_sequencing_timers dut (.*);
  converter_model conv (.i_clock(i_clock), .i_enable(o_converter_enable_out), .i_stuck(stuck),
                        .i_ramp(8'h28), .o_uv_reached(i_uv_reached));
  initial begin
    forever #5 i_clock = ~i_clock;
  end
  // ===
  // Shared timebase: one falling edge every four cycles, pulled high while absent.
  always @(negedge i_clock) begin
    cycles <= cycles + 1;
    if (!share_run) i_share_clk <= 1'h1;
    else if (cycles[0]) i_share_clk <= ~i_share_clk;
    if (cycles == 30000) begin
      failures = failures + 1;
      final_report();
    end
  end
  // ===
  // Helpers
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic chk_win(input int got, input int lo, input int hi, input string what);
    samples_checked++;
    if (got < lo || got > hi) begin
      failures++;
      $display("MISMATCH t=%0t %s took %0d cycles", $time, what, got);
    end
  endtask
  task automatic idle(input int k);
    repeat (k) @(negedge i_clock);
  endtask
  // The answer stands for one cycle, so it is judged at the next falling edge.
  task automatic cmd(input logic wr, input logic [7:0] code, input logic [1:0] pg,
                     input logic [15:0] d);
    @(negedge i_clock);
    i_cmd_valid = 1'h1;
    i_cmd_write = wr;
    i_cmd_code = code;
    i_cmd_page = pg;
    i_cmd_wdata = d;
    @(negedge i_clock);
    i_cmd_valid = 1'h0;
  endtask
  task automatic rd(input logic [7:0] code, input logic [1:0] pg, input logic [15:0] exp);
    cmd(1'h0, code, pg, 16'h0000);
    chk(o_cmd_rvalid, 16'h0001, "rvalid");
    chk(o_cmd_rdata, exp, "rdata");
  endtask
  function automatic logic pick(input int s, input int n);
    logic [3:0] w;
    w = s == 0 ? o_converter_enable_out : s == 1 ? o_dac_soft_connect :
        s == 2 ? o_uv_unmask : o_power_up_timeout_fault;
    return w[n];
  endfunction
  task automatic wait_out(input int s, input int n, input logic v, output int t);
    t = 0;
    while (pick(s, n) !== v && t < 9000) begin
      @(negedge i_clock);
      t++;
    end
  endtask
  task automatic pin_off(input int k);
    i_control_pin = 1'h0;
    idle(k);
    i_control_pin = 1'h1;
  endtask
  // ===
  // Scenarios
  task automatic t_regs();
    rd(`CMD_ON_DELAY, 2'h3, `RST_ON_DELAY);
    rd(`CMD_RISE_TIME, 2'h0, `RST_RISE_TIME);
    rd(`CMD_PU_TIMEOUT, 2'h3, `RST_PU_TIMEOUT);
    rd(`CMD_OFF_DELAY, 2'h1, `RST_OFF_DELAY);
    rd(`CMD_RESTART_HOLD, 2'h2, `RST_RESTART_HOLD);
    cmd(1'h1, `CMD_ON_DELAY, 2'h1, 16'h7BFF);
    cmd(1'h1, `CMD_RESTART_HOLD, 2'h0, 16'h7FFF);
    rd(`CMD_ON_DELAY, 2'h1, 16'h7BFF);
    rd(`CMD_ON_DELAY, 2'h2, `RST_ON_DELAY);
    rd(`CMD_RESTART_HOLD, 2'h3, 16'h7FFF);
    cmd(1'h1, 8'h63, 2'h0, 16'hAAAA);
    chk(o_cmd_nack, 16'h0001, "write nack");
    cmd(1'h0, 8'h63, 2'h0, 16'h0000);
    chk(o_cmd_nack, 16'h0001, "read nack");
    chk(o_cmd_rdata, 16'h7FFF, "rdata kept");
  endtask
  // Word 0xD808 is 0.25 ms, 25 steps; 0x0001 is 1 ms, 100 steps.
  task automatic t_on();
    int t, u;
    cmd(1'h1, `CMD_ON_DELAY, 2'h0, 16'hD808);
    cmd(1'h1, `CMD_RISE_TIME, 2'h0, 16'hD808);
    cmd(1'h1, `CMD_PU_TIMEOUT, 2'h0, 16'h0001);
    i_op_on[0] = 1'h1;
    wait_out(0, 0, 1'h1, t);
    chk_win(t, 92, 112, "on delay");
    wait_out(2, 0, 1'h1, t);
    chk_win(t, 39, 44, "unmask");
    wait_out(1, 0, 1'h1, u);
    chk_win(t + u, 92, 112, "rise time");
    idle(400);
    chk(o_power_up_timeout_fault[0], 16'h0000, "fault after unmask");
  endtask
  task automatic t_timeout();
    int t;
    stuck = 4'h6;
    cmd(1'h1, `CMD_ON_DELAY, 2'h1, 16'h8000);
    cmd(1'h1, `CMD_RISE_TIME, 2'h1, 16'hD808);
    cmd(1'h1, `CMD_PU_TIMEOUT, 2'h1, 16'hD808);
    cmd(1'h1, `CMD_ON_DELAY, 2'h2, 16'h8000);
    cmd(1'h1, `CMD_PU_TIMEOUT, 2'h2, 16'h8000);
    i_op_on[2:1] = 2'h3;
    wait_out(0, 1, 1'h1, t);
    wait_out(3, 1, 1'h1, t);
    chk_win(t, 92, 112, "timeout");
    idle(2000);
    chk(o_converter_enable_out[2], 16'h0001, "zero on delay");
    chk(o_dac_soft_connect[1], 16'h0000, "mode 01 soft-connect");
    chk(o_power_up_timeout_fault[2], 16'h0000, "zero timeout");
    chk(o_uv_unmask[2:1], 16'h0000, "masked while low");
  endtask
  // Word 0xC802 is 200/128 steps: rounds to 2, where truncation would give 1.
  task automatic t_off();
    int t;
    cmd(1'h1, `CMD_OFF_DELAY, 2'h0, 16'hD808);
    cmd(1'h1, `CMD_OFF_DELAY, 2'h1, 16'hC802);
    i_op_on[0] = 1'h0;
    wait_out(0, 0, 1'h0, t);
    chk_win(t, 92, 112, "shared off delay");
    share_run = 1'h0;
    i_share_clk_ok = 1'h0;
    i_op_on[1:0] = 2'h1;
    wait_out(0, 1, 1'h0, t);
    chk_win(t, 1000, 2010, "internal off delay");
    chk(o_converter_enable_out[0], 16'h0000, "on delay frozen");
    share_run = 1'h1;
    i_share_clk_ok = 1'h1;
    wait_out(0, 0, 1'h1, t);
    chk_win(t, 88, 112, "on delay resumed");
  endtask
  // Hold 0x0004 is 20 steps of 80 cycles, counted from the drop 1000 cycles
  // into the off period; off periods of 1100 cycles pass the filter.
  task automatic t_restart();
    int t;
    cmd(1'h1, `CMD_ON_DELAY, 2'h3, 16'h8000);
    cmd(1'h1, `CMD_OFF_DELAY, 2'h3, 16'h8000);
    cmd(1'h1, `CMD_RESTART_HOLD, 2'h0, 16'h0004);
    i_op_on[3] = 1'h1;
    wait_out(0, 3, 1'h1, t);
    pin_off(50);
    idle(60);
    chk(o_converter_enable_out[3], 16'h0001, "short off filtered");
    pin_off(1100);
    chk(o_converter_enable_out[3], 16'h0000, "restart drop");
    chk(o_converter_enable_out[0], 16'h0001, "independent kept");
    wait_out(0, 3, 1'h1, t);
    chk_win(t, 1400, 1520, "restart hold");
    cmd(1'h1, `CMD_RESTART_HOLD, 2'h2, 16'hD808);
    pin_off(1100);
    wait_out(0, 3, 1'h1, t);
    chk_win(t, 0, 20, "long off unchanged");
    cmd(1'h1, `CMD_RESTART_HOLD, 2'h1, 16'h0000);
    i_control_pin = 1'h0;
    wait_out(0, 3, 1'h0, t);
    chk_win(t, 0, 10, "hold disabled off");
    i_control_pin = 1'h1;
    wait_out(0, 3, 1'h1, t);
    chk_win(t, 0, 10, "hold disabled on");
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    idle(16);
    i_rst = 1'h0;
    t_regs();
    t_on();
    t_timeout();
    t_off();
    t_restart();
    final_report();
  end
endmodule
bind channel_sequencing_timers channel_sequencing_timers_monitor mon (.*);
`default_nettype wire

// ===== verif/converter_model.sv
/* Converter model: one DC/DC stage per channel that ramps after enable.
   Assumes enable levels from the block and a ramp length from the bench. */
`default_nettype none
module converter_model (
  // Clock
  input wire logic        i_clock,
  // Control
  input wire logic [3:0]  i_enable,
  input wire logic [3:0]  i_stuck,
  input wire logic [7:0]  i_ramp,
  // Status
  output var logic [3:0]  o_uv_reached
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] ramp_q [4];
  // A stuck stage never reaches its limit, which is how a timeout is provoked.
  always_ff @(posedge i_clock) begin
    for (int n = 0; n < 4; n++) begin
      if (!i_enable[n] || i_stuck[n]) ramp_q[n] <= 8'h00;
      else if (ramp_q[n] != i_ramp) ramp_q[n] <= ramp_q[n] + 8'h01;
    end
  end
  always_comb begin
    for (int n = 0; n < 4; n++) o_uv_reached[n] = i_enable[n] && !i_stuck[n] && ramp_q[n] == i_ramp;
  end
endmodule
`default_nettype wire
